// ### shared/rae_pkg.sv
// constants for the reactive and apparent energy accumulation block
// assumes: an apb master on mclk, dsp inputs on the same clock
package rae_pkg;
  // ***************************************************
  // register indices (byte address is index times four)
  // ***************************************************
  localparam logic [7:0] IDX_WAVE_DATA = 8'h01;
  localparam logic [7:0] IDX_REACT_TOTAL = 8'h04;
  localparam logic [7:0] IDX_LINE_REACT = 8'h06;
  localparam logic [7:0] IDX_APP_TOTAL = 8'h07;
  localparam logic [7:0] IDX_APP_RDCLR = 8'h08;
  localparam logic [7:0] IDX_WAVE_SEL = 8'h0D;
  localparam logic [7:0] IDX_ACC_MODE = 8'h0F;
  localparam logic [7:0] IDX_HALF_CYC = 8'h12;
  localparam logic [7:0] IDX_APP_GAIN = 8'h1F;
  localparam logic [7:0] IDX_APP_DIV = 8'h26;
  localparam logic [7:0] IDX_IRQ_EN_MID = 8'hDA;
  localparam logic [7:0] IDX_IRQ_EN_HIGH = 8'hDB;
  localparam logic [7:0] IDX_IRQ_ST_MID = 8'hDD;
  localparam logic [7:0] IDX_IRQ_ST_HIGH = 8'hDE;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int ACC_ANTITAMPER_BIT = 2;
  localparam int ACC_ABSOLUTE_BIT = 3;
  localparam int CYCLE_END_BIT = 2;
  localparam int WAVE_ENABLE_BIT = 5;
  localparam int HALF_FULL_BIT = 2;
  localparam int OVERFLOW_BIT = 5;
  localparam logic [2:0] WAVE_SRC_APPARENT = 3'h3;
  localparam int WAVE_RATE_LSB = 3;
  // ***************************************************
  // reset values and counts
  // ***************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_HALF_CYC = 16'h0000;
  localparam logic [11:0] RESET_GAIN = 12'h000;
  localparam int STEP_CYCLES = 5;
  localparam real CLOCK_MHZ = 100.0;
  localparam real PULSE_WIDTH_US = 0.5;
  localparam int PULSE_CYCLES = int'(PULSE_WIDTH_US * CLOCK_MHZ);
  localparam int GAIN_SHIFT = 12;
  localparam int REACT_ACC_W = 49;
  localparam int APP_ACC_W = 48;
  localparam int REG_W = 24;
endpackage

// ### rtl/rae_energy_accum.sv
// reactive and apparent energy accumulation with an apb register file
// assumes: power, rms and zero-crossing inputs come from mclk logic
`timescale 1ns/1ps
module rae_energy_accum
  import rae_pkg::*;
#(
  parameter int PW = 24 // width of power and rms inputs
) (
  input wire logic mclk, // 100 mhz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic signed [PW-1:0] reactivePower, // calibrated var
  input wire logic signed [PW-1:0] activePower, // active power
  input wire logic varNoLoad, // var below no-load threshold
  input wire logic [PW-1:0] voltageRms, // offset-corrected vrms
  input wire logic [PW-1:0] currentRms, // offset-corrected irms
  input wire logic zeroCross, // voltage zero crossing pulse
  input wire logic sampleTick, // 25.6 ksps base pulse
  output logic energyIrq, // pending energy interrupt, level
  output logic energyPulseOutput_n, // reactive pulse, active low
  output logic waveValid, // new waveform sample pulse
  output logic [REG_W-1:0] waveData // waveform sample
);
  // ***************************************************
  // parameter check
  // ***************************************************
  if (PW < REG_W) begin : gBadWidth
    $error("PW must be at least 24");
  end

  // ***************************************************
  // registers
  // ***************************************************
  logic [7:0] waveSel_q;
  logic [7:0] accumulation_mode_control_q;
  logic [15:0] halfCyc_q;
  logic [11:0] appGain_q;
  logic [7:0] appDiv_q;
  logic [7:0] irqEnMid_q;
  logic [7:0] irqEnHigh_q;
  logic [7:0] irqStMid_q;
  logic [7:0] irqStHigh_q;
  logic [REG_W-1:0] lineReact_q;

  logic [7:0] idx;
  logic wrEn;
  logic rdEn;
  logic mapped;
  assign idx = paddr[9:2];
  assign wrEn = ce && psel && penable && pwrite;
  assign rdEn = ce && psel && penable && !pwrite;

  // decode of the mapped words
  always_comb begin
    case (idx)
      IDX_WAVE_DATA, IDX_REACT_TOTAL, IDX_LINE_REACT, IDX_APP_TOTAL,
      IDX_APP_RDCLR, IDX_WAVE_SEL, IDX_ACC_MODE, IDX_HALF_CYC,
      IDX_APP_GAIN, IDX_APP_DIV, IDX_IRQ_EN_MID, IDX_IRQ_EN_HIGH,
      IDX_IRQ_ST_MID, IDX_IRQ_ST_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states: read data is registered in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  // control registers written by software
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      waveSel_q <= RESET_BYTE;
      accumulation_mode_control_q <= RESET_BYTE;
      halfCyc_q <= RESET_HALF_CYC;
      appGain_q <= RESET_GAIN;
      appDiv_q <= RESET_BYTE;
      irqEnMid_q <= RESET_BYTE;
      irqEnHigh_q <= RESET_BYTE;
    end else if (wrEn) begin
      case (idx)
        IDX_WAVE_SEL: waveSel_q <= pwdata[7:0];
        IDX_ACC_MODE: accumulation_mode_control_q <= pwdata[7:0];
        IDX_HALF_CYC: halfCyc_q <= pwdata[15:0];
        IDX_APP_GAIN: appGain_q <= pwdata[11:0];
        IDX_APP_DIV: appDiv_q <= pwdata[7:0];
        IDX_IRQ_EN_MID: irqEnMid_q <= pwdata[7:0];
        IDX_IRQ_EN_HIGH: irqEnHigh_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ***************************************************
  // five-clock accumulation step
  // ***************************************************
  logic [2:0] stepCnt_q;
  logic step;
  assign step = ce && (stepCnt_q == 3'(STEP_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stepCnt_q <= 3'h0;
    end else if (ce) begin
      stepCnt_q <= step ? 3'h0 : stepCnt_q + 3'h1;
    end
  end

  // ***************************************************
  // reactive increment
  // ***************************************************
  logic signed [REACT_ACC_W-1:0] varExt;
  logic signed [REACT_ACC_W-1:0] varDelta;
  assign varExt = REACT_ACC_W'(reactivePower);

  // no-load gating stays active whatever mode is chosen
  always_comb begin
    if (varNoLoad) begin
      varDelta = '0;
    end else if (accumulation_mode_control_q[ACC_ABSOLUTE_BIT]) begin
      // absolute wins when both bits are set
      varDelta = varExt[REACT_ACC_W-1] ? -varExt : varExt;
    end else if (accumulation_mode_control_q[ACC_ANTITAMPER_BIT]) begin
      varDelta = activePower[PW-1] ? -varExt : varExt;
    end else begin
      varDelta = varExt;
    end
  end

  // internal reactive accumulator, feeds the pulse output too
  logic signed [REACT_ACC_W-1:0] reactAcc_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reactAcc_q <= '0;
    end else if (step) begin
      reactAcc_q <= reactAcc_q + varDelta;
    end
  end

  // ***************************************************
  // reactive pulse output
  // ***************************************************
  // a pulse per lsb of the readable word; the lsb weight ties the
  // pulse rate to the same mode-dependent accumulation
  localparam int PULSE_BIT = REACT_ACC_W - REG_W;
  logic pulseTap_q;
  logic [7:0] pulseCnt_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulseTap_q <= 1'b0;
      pulseCnt_q <= 8'h00;
    end else if (ce) begin
      pulseTap_q <= reactAcc_q[PULSE_BIT];
      if (pulseTap_q != reactAcc_q[PULSE_BIT]) begin
        pulseCnt_q <= 8'(PULSE_CYCLES);
      end else if (pulseCnt_q != 8'h00) begin
        pulseCnt_q <= pulseCnt_q - 8'h01;
      end
    end
  end
  assign energyPulseOutput_n = (pulseCnt_q == 8'h00);

  // ***************************************************
  // line-cycle reactive accumulation
  // ***************************************************
  logic lineRun_q;
  logic [15:0] lineCnt_q;
  logic signed [REACT_ACC_W-1:0] lineAcc_q;
  logic halfCycWr;
  logic cycleEnd;
  assign halfCycWr = wrEn && (idx == IDX_HALF_CYC);
  // a zero count never completes a cycle
  assign cycleEnd = ce && lineRun_q && zeroCross && !halfCycWr &&
    (halfCyc_q != 16'h0000) && (lineCnt_q + 16'h0001 == halfCyc_q);

  // half-cycle counter disarmed by a count write, armed by the next crossing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lineRun_q <= 1'b0;
      lineCnt_q <= 16'h0000;
    end else if (halfCycWr) begin
      lineRun_q <= 1'b0;
      lineCnt_q <= 16'h0000;
    end else if (ce && zeroCross) begin
      lineRun_q <= 1'b1;
      if (cycleEnd || !lineRun_q) begin
        lineCnt_q <= 16'h0000;
      end else begin
        lineCnt_q <= lineCnt_q + 16'h0001;
      end
    end
  end

  // partial line energy, same increment as the ordinary accumulator
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lineAcc_q <= '0;
    end else if (halfCycWr || cycleEnd ||
        (ce && zeroCross && !lineRun_q)) begin
      lineAcc_q <= '0;
    end else if (step && lineRun_q) begin
      lineAcc_q <= lineAcc_q + varDelta;
    end
  end

  // result word, overwritten at every cycle end whether read or not
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lineReact_q <= '0;
    end else if (halfCycWr) begin
      lineReact_q <= '0;
    end else if (cycleEnd) begin
      // a step on the closing crossing belongs to the closing result
      lineReact_q <= REG_W'((step ? lineAcc_q + varDelta : lineAcc_q) >>>
        PULSE_BIT);
    end
  end

  // ***************************************************
  // apparent power and gain
  // ***************************************************
  logic [2*PW-1:0] rmsProduct;
  logic signed [REG_W:0] appPower;
  logic signed [13:0] gainFactor;
  logic signed [REG_W+14:0] appScaledFull;
  logic signed [REG_W+2:0] appScaled;
  assign rmsProduct = voltageRms * currentRms;
  assign appPower = {1'b0, rmsProduct[2*PW-1 -: REG_W]};
  assign gainFactor = 14'sh1000 + 14'(signed'(appGain_q));
  assign appScaledFull = appPower * gainFactor;
  assign appScaled = (REG_W+3)'(appScaledFull >>> GAIN_SHIFT);

  // ***************************************************
  // apparent energy accumulators
  // ***************************************************
  logic signed [APP_ACC_W-1:0] appDelta;
  logic [APP_ACC_W-1:0] appAcc_q;
  logic [APP_ACC_W-1:0] appRc_q;
  logic [APP_ACC_W-1:0] appAccNext;
  logic [7:0] divEff;
  logic [APP_ACC_W-1:0] appQuot;
  logic [APP_ACC_W-1:0] rcQuot;
  logic rcRead;
  assign appDelta = APP_ACC_W'(appScaled);
  assign appAccNext = APP_ACC_W'(signed'(appAcc_q) + appDelta);
  assign divEff = (appDiv_q == 8'h00) ? 8'h01 : appDiv_q;
  assign appQuot = appAcc_q / APP_ACC_W'(divEff);
  assign rcQuot = appRc_q / APP_ACC_W'(divEff);
  assign rcRead = rdEn && (idx == IDX_APP_RDCLR);

  // total accumulator, never cleared by software
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      appAcc_q <= '0;
    end else if (step) begin
      appAcc_q <= appAccNext;
    end
  end

  // read-clear copy; a step landing on the read is kept, not lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      appRc_q <= '0;
    end else if (rcRead) begin
      appRc_q <= step ? APP_ACC_W'(appDelta) : '0;
    end else if (step) begin
      appRc_q <= APP_ACC_W'(signed'(appRc_q) + appDelta);
    end
  end

  // ***************************************************
  // apparent half-full and overflow detection
  // ***************************************************
  logic appHalf_q;
  logic appTop_q;
  logic halfFullEvt;
  logic overflowEvt;
  // half-full uses bit 23 of the unsigned word, not bit 22
  assign halfFullEvt = ce && !appHalf_q && appQuot[APP_ACC_W-1];
  assign overflowEvt = ce && appTop_q && !appQuot[APP_ACC_W-1] &&
    !appDelta[APP_ACC_W-1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      appHalf_q <= 1'b0;
      appTop_q <= 1'b0;
    end else if (ce) begin
      appHalf_q <= appQuot[APP_ACC_W-1];
      appTop_q <= appQuot[APP_ACC_W-1];
    end
  end

  // ***************************************************
  // status flags, write one to clear, set wins
  // ***************************************************
  logic [7:0] setMid;
  logic [7:0] setHigh;
  logic [7:0] clrMid;
  logic [7:0] clrHigh;
  always_comb begin
    setMid = 8'h00;
    setHigh = 8'h00;
    setMid[HALF_FULL_BIT] = halfFullEvt;
    setMid[OVERFLOW_BIT] = overflowEvt;
    setHigh[CYCLE_END_BIT] = cycleEnd;
  end
  assign clrMid = (wrEn && idx == IDX_IRQ_ST_MID) ? pwdata[7:0] : 8'h00;
  assign clrHigh = (wrEn && idx == IDX_IRQ_ST_HIGH) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqStMid_q <= RESET_BYTE;
      irqStHigh_q <= RESET_BYTE;
    end else begin
      irqStMid_q <= (irqStMid_q & ~clrMid) | setMid;
      irqStHigh_q <= (irqStHigh_q & ~clrHigh) | setHigh;
    end
  end

  // pending while any enabled flag stands
  logic [7:0] enMidMask;
  logic [7:0] enHighMask;
  assign enMidMask = 8'h24;
  assign enHighMask = 8'h04;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      energyIrq <= 1'b0;
    end else begin
      energyIrq <= |(irqStMid_q & irqEnMid_q & enMidMask) ||
        |(irqStHigh_q & irqEnHigh_q & enHighMask);
    end
  end

  // ***************************************************
  // apparent waveform sampling
  // ***************************************************
  logic [2:0] rateCnt_q;
  logic [2:0] rateMask;
  logic waveOn;
  // base rate halved by each step of the two rate bits
  assign rateMask = 3'((4'h1 << waveSel_q[WAVE_RATE_LSB +: 2]) - 4'h1);
  assign waveOn = irqEnHigh_q[WAVE_ENABLE_BIT] &&
    (waveSel_q[2:0] == WAVE_SRC_APPARENT);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rateCnt_q <= 3'h0;
      waveValid <= 1'b0;
      waveData <= '0;
    end else if (ce) begin
      waveValid <= 1'b0;
      if (sampleTick) begin
        rateCnt_q <= (rateCnt_q & rateMask) == rateMask ? 3'h0 :
          rateCnt_q + 3'h1;
        if (waveOn && (rateCnt_q & rateMask) == rateMask) begin
          waveValid <= 1'b1;
          waveData <= appScaled[REG_W-1:0];
        end
      end
    end
  end

  // ***************************************************
  // read data, captured in the setup cycle
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (idx)
        IDX_WAVE_DATA: prdata <= 32'(waveData);
        IDX_REACT_TOTAL: prdata <= 32'(reactAcc_q[REACT_ACC_W-1 -: REG_W]);
        IDX_LINE_REACT: prdata <= 32'(lineReact_q);
        IDX_APP_TOTAL: prdata <= 32'(appQuot[APP_ACC_W-1 -: REG_W]);
        IDX_APP_RDCLR: prdata <= 32'(rcQuot[APP_ACC_W-1 -: REG_W]);
        IDX_WAVE_SEL: prdata <= 32'(waveSel_q);
        IDX_ACC_MODE: prdata <= 32'(accumulation_mode_control_q);
        IDX_HALF_CYC: prdata <= 32'(halfCyc_q);
        IDX_APP_GAIN: prdata <= 32'(appGain_q);
        IDX_APP_DIV: prdata <= 32'(appDiv_q);
        IDX_IRQ_EN_MID: prdata <= 32'(irqEnMid_q);
        IDX_IRQ_EN_HIGH: prdata <= 32'(irqEnHigh_q);
        IDX_IRQ_ST_MID: prdata <= 32'(irqStMid_q);
        IDX_IRQ_ST_HIGH: prdata <= 32'(irqStHigh_q);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### tb/rae_front_model.sv
// front-end model: voltage zero crossings and waveform base ticks
// assumes: same mclk as the block, pulses one clock wide
`timescale 1ns/1ps
module rae_front_model #(
  parameter int ZC_PERIOD = 160, // clocks per half line cycle
  parameter int TICK_PERIOD = 20 // clocks per base sample
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  output logic zeroCross, // crossing pulse
  output logic sampleTick // base sample pulse
);
  int zcCnt_q;
  int tickCnt_q;
  // shortened mains period; a multiple of five keeps steps exact
  always_ff @(posedge mclk) begin
    if (!rst_n || zcCnt_q == ZC_PERIOD - 1) begin
      zcCnt_q <= 0;
    end else begin
      zcCnt_q <= zcCnt_q + 1;
    end
  end
  // base tick far faster than real, to keep the run short
  always_ff @(posedge mclk) begin
    if (!rst_n || tickCnt_q == TICK_PERIOD - 1) begin
      tickCnt_q <= 0;
    end else begin
      tickCnt_q <= tickCnt_q + 1;
    end
  end
  assign zeroCross = rst_n && zcCnt_q == ZC_PERIOD - 1;
  assign sampleTick = rst_n && tickCnt_q == TICK_PERIOD - 1;
endmodule

// ### tb/rae_energy_accum_props.sv
// port checker for the energy accumulation block
// assumes: bound into rae_energy_accum, one clock domain
`timescale 1ns/1ps
module rae_energy_accum_props
  import rae_pkg::*;
#(
  parameter int PW = 24 // power input width
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [9:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic sampleTick, // base sample pulse
  input wire logic energyIrq, // interrupt level
  input wire logic energyPulseOutput_n, // reactive pulse
  input wire logic waveValid // sample strobe
);
  // *****
  // helper logic
  // *****
  logic [7:0] enMid_q;
  logic [7:0] enHigh_q;
  logic anyEn;
  int lowCnt_q;
  // shadow enables: the irq level may only follow them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enMid_q <= 8'h00;
      enHigh_q <= 8'h00;
    end else if (psel && penable && pwrite && ce) begin
      if (paddr[9:2] == IDX_IRQ_EN_MID) enMid_q <= pwdata[7:0];
      if (paddr[9:2] == IDX_IRQ_EN_HIGH) enHigh_q <= pwdata[7:0];
    end
  end
  assign anyEn = enMid_q[HALF_FULL_BIT] || enMid_q[OVERFLOW_BIT] ||
    enHigh_q[CYCLE_END_BIT];
  // length of the running low phase of the pulse
  always_ff @(posedge mclk) begin
    if (!rst_n || energyPulseOutput_n) begin
      lowCnt_q <= 0;
    end else begin
      lowCnt_q <= lowCnt_q + 1;
    end
  end
  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      IDX_WAVE_DATA, IDX_REACT_TOTAL, IDX_LINE_REACT, IDX_APP_TOTAL,
      IDX_APP_RDCLR, IDX_WAVE_SEL, IDX_ACC_MODE, IDX_HALF_CYC,
      IDX_APP_GAIN, IDX_APP_DIV, IDX_IRQ_EN_MID, IDX_IRQ_EN_HIGH,
      IDX_IRQ_ST_MID, IDX_IRQ_ST_HIGH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rdAcc(idx);
    psel && penable && !pwrite && paddr[9:2] == idx;
  endsequence
  sequence pulseLow;
    !energyPulseOutput_n [*8];
  endsequence
  AST_READY_NO_WAIT: assert property (
    pready == (psel && penable)) else $error("pready late");
  AST_UNMAPPED_ERR: assert property (
    pslverr == (psel && penable && !mapped(paddr[9:2])))
    else $error("pslverr wrong");
  AST_LINE_WIDTH: assert property (
    rdAcc(IDX_LINE_REACT) |-> prdata[31:24] == 8'h00)
    else $error("line register too wide");
  AST_RDCLR_WIDTH: assert property (
    rdAcc(IDX_APP_RDCLR) |-> prdata[31:24] == 8'h00)
    else $error("read-clear too wide");
  AST_GAIN_WIDTH: assert property (
    rdAcc(IDX_APP_GAIN) |-> prdata[31:12] == 20'h00000)
    else $error("gain too wide");
  AST_WAVE_FROM_TICK: assert property (
    waveValid |-> $past(sampleTick)) else $error("sample off tick");
  AST_IRQ_ENABLED: assert property (
    energyIrq |-> anyEn || $past(anyEn)) else $error("irq not enabled");
  AST_PULSE_START: assert property (
    $fell(energyPulseOutput_n) |-> pulseLow) else $error("pulse short");
  AST_PULSE_WIDTH: assert property (
    $rose(energyPulseOutput_n) |-> lowCnt_q == PULSE_CYCLES)
    else $error("pulse width wrong");
endmodule
bind rae_energy_accum rae_energy_accum_props #(.PW(PW)) props_u (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sampleTick(sampleTick),
  .energyIrq(energyIrq), .energyPulseOutput_n(energyPulseOutput_n),
  .waveValid(waveValid));

// ### tb/tb_top.sv
// self-checking bench for the energy accumulation block
// assumes: front model makes crossings and ticks, tasks drive apb
`timescale 1ns/1ps
module tb_top
  import rae_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic signed [23:0] reactivePower = 24'sh000000;
  logic signed [23:0] activePower = 24'sh000001;
  logic varNoLoad = 1'b0;
  logic [23:0] voltageRms = 24'h000000;
  logic [23:0] currentRms = 24'h000000;
  logic [31:0] prdata;
  logic pready, pslverr, zeroCross, sampleTick, energyIrq;
  logic energyPulseOutput_n, waveValid, pulseLast;
  logic [23:0] waveData;
  int errors = 0;
  int n_checks = 0;
  int pulseFalls = 0;
  // *****
  // clock, reset, instances
  // *****
  always #5 mclk = ~mclk;
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
  end
  rae_energy_accum dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reactivePower(reactivePower), .activePower(activePower),
    .varNoLoad(varNoLoad), .voltageRms(voltageRms),
    .currentRms(currentRms), .zeroCross(zeroCross),
    .sampleTick(sampleTick), .energyIrq(energyIrq),
    .energyPulseOutput_n(energyPulseOutput_n), .waveValid(waveValid),
    .waveData(waveData));
  rae_front_model front_u (.mclk(mclk), .rst_n(rst_n),
    .zeroCross(zeroCross), .sampleTick(sampleTick));
  // count falling pulse edges, read as a difference by scenarios
  always @(posedge mclk) begin
    pulseLast <= energyPulseOutput_n;
    if (pulseLast === 1'b1 && energyPulseOutput_n === 1'b0) begin
      pulseFalls <= pulseFalls + 1;
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen,
        exp);
    end
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrReg(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask
  task automatic rdReg(input logic [7:0] idx, output logic [31:0] rd);
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
  endtask
  task automatic waitIrq(input int bound);
    int n;
    n = 0;
    while (energyIrq !== 1'b1 && n < bound) begin
      @(posedge mclk);
      n++;
    end
    if (energyIrq !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask
  // *****
  // scenarios
  // *****
  task automatic t_reset();
    logic [31:0] v;
    logic err;
    rdReg(IDX_ACC_MODE, v);
    check(v, 32'h0, "mode after reset");
    apb(1'b0, 8'h30, 32'h0, v, err);
    check({v[30:0], err}, 32'h1, "unmapped read");
    // a write while the enable is low must leave the mode untouched
    @(posedge mclk);
    ce <= 1'b0;
    wrReg(IDX_ACC_MODE, 32'h4);
    ce <= 1'b1;
    rdReg(IDX_ACC_MODE, v);
    check(v, 32'h0, "write with ce low");
  endtask
  // exact multiple of five clocks gives an exact step count
  task automatic appWindow(input int steps);
    @(posedge mclk);
    voltageRms <= 24'h100000;
    currentRms <= 24'h100000;
    repeat (5 * steps) @(posedge mclk);
    voltageRms <= 24'h000000;
    currentRms <= 24'h000000;
    repeat (20) @(posedge mclk);
  endtask
  task automatic t_apparent();
    logic [31:0] v;
    appWindow(512);
    rdReg(IDX_APP_RDCLR, v);
    check(v, 32'h2, "read-clear energy");
    rdReg(IDX_APP_RDCLR, v);
    check(v, 32'h0, "read-clear again");
    wrReg(IDX_APP_GAIN, 32'h7FF);
    rdReg(IDX_APP_GAIN, v);
    check(v, 32'h7FF, "gain readback");
    appWindow(1024);
    rdReg(IDX_APP_RDCLR, v);
    check(v, 32'h5, "scaled energy");
    rdReg(IDX_APP_TOTAL, v);
    check(v, 32'h7, "total energy");
    wrReg(IDX_APP_DIV, 32'h1);
    rdReg(IDX_APP_TOTAL, v);
    check(v, 32'h7, "divide by one");
    wrReg(IDX_APP_DIV, 32'h2);
    rdReg(IDX_APP_TOTAL, v);
    check(v, 32'h3, "divide by two");
  endtask
  // 64 steps of 2^20 per cycle make two line lsbs
  task automatic t_line(input logic [7:0] mode, input int react,
      input int active, input logic noload, input logic [31:0] exp);
    logic [31:0] v;
    int falls;
    @(posedge mclk);
    reactivePower <= 24'(react);
    activePower <= 24'(active);
    varNoLoad <= noload;
    wrReg(IDX_ACC_MODE, {24'h0, mode});
    wrReg(IDX_HALF_CYC, 32'h2);
    rdReg(IDX_LINE_REACT, v);
    check(v, 32'h0, "line after count write");
    falls = pulseFalls;
    waitIrq(800);
    rdReg(IDX_LINE_REACT, v);
    check(v, exp, "line result");
    rdReg(IDX_IRQ_ST_HIGH, v);
    check(v & 32'h4, 32'h4, "cycle end flag");
    wrReg(IDX_IRQ_ST_HIGH, 32'h4);
    repeat (3) @(posedge mclk);
    check({31'h0, energyIrq}, 32'h0, "irq after clear");
    check(32'(pulseFalls != falls), {31'h0, !noload}, "pulse");
  endtask
  task automatic t_overwrite();
    logic [31:0] v;
    @(posedge mclk);
    reactivePower <= 24'sh100000;
    varNoLoad <= 1'b0;
    wrReg(IDX_ACC_MODE, 32'h0);
    wrReg(IDX_HALF_CYC, 32'h2);
    waitIrq(800);
    wrReg(IDX_IRQ_ST_HIGH, 32'h4);
    reactivePower <= 24'sh000000;
    // irq level drops one edge after the clear, do not see the old one
    repeat (2) @(posedge mclk);
    waitIrq(340);
    rdReg(IDX_LINE_REACT, v);
    check(v, 32'h0, "line overwritten");
  endtask
  task automatic t_wave(input logic [7:0] en, input int rate,
      input int exp);
    int cnt;
    cnt = 0;
    wrReg(IDX_WAVE_SEL, 32'(WAVE_SRC_APPARENT) | 32'(rate << 3));
    wrReg(IDX_IRQ_EN_HIGH, {24'h0, en});
    repeat (640) begin
      @(posedge mclk);
      if (waveValid === 1'b1) begin
        cnt++;
        check({8'h0, waveData}, 32'h17FF0, "wave data");
      end
    end
    check(32'(cnt), 32'(exp), "wave samples");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    t_reset();
    t_apparent();
    wrReg(IDX_IRQ_EN_HIGH, 32'h4);
    t_line(8'h00, 1 << 20, 1, 1'b0, 32'h2);
    t_line(8'h00, -(1 << 20), 1, 1'b0, 32'hFFFFFE);
    t_line(8'h04, 1 << 20, -1, 1'b0, 32'hFFFFFE);
    t_line(8'h04, -(1 << 20), -1, 1'b0, 32'h2);
    t_line(8'h08, -(1 << 20), 1, 1'b0, 32'h2);
    t_line(8'h0C, 1 << 20, -1, 1'b0, 32'h2);
    t_line(8'h08, 1 << 20, 1, 1'b1, 32'h0);
    t_overwrite();
    // power word 0x10000, gain 0x7FF: 0x10000 * 6143 / 4096 = 0x17FF0
    voltageRms <= 24'h100000;
    currentRms <= 24'h100000;
    for (int r = 0; r < 4; r++) begin
      t_wave(8'h24, r, 32 >> r);
    end
    t_wave(8'h04, 0, 0);
    finish_test();
  end
  // watchdog against a hang anywhere in the sequence
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule
